// [dma_partner.sv]
`timescale 1ns/1ps
// ==========================================================
// transfer engine model: acknowledges each request after a delay
module dma_partner (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic [3:0] i_delay,
   input wire logic i_dma_request_n,
   output logic o_dma_ack
);
   logic [3:0] wait_reg; // cycles spent on the pending request
   logic [3:0] wait_next;
   logic ack_next;
   // one-cycle acknowledge, never while idle, for every request
   always_comb begin
      wait_next = 4'h0;
      ack_next = 1'b0;
      if (!i_dma_request_n && !o_dma_ack) begin
         if (wait_reg >= i_delay) ack_next = 1'b1;
         else wait_next = wait_reg + 4'h1;
      end
   end
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         wait_reg <= 4'h0;
         o_dma_ack <= 1'b0;
      end else begin
         wait_reg <= wait_next;
         o_dma_ack <= ack_next;
      end
   end
endmodule

// [pwm_timer_control.sv]
`timescale 1ns/1ps
// ==========================================================
// five-channel timer: registers, clock division, dead zone, DMA
module pwm_timer_control (
   input wire logic I_CLK,
   input wire logic I_RESET,
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [31:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   output logic [31:0] O_PRDATA,
   output logic O_PREADY,
   output logic O_PSLVERR,
   input wire logic I_DMA_ACK,
   output logic O_DMA_REQUEST_N,
   output logic [4:0] O_INT_REQUEST,
   output logic [3:0] O_TIMER_OUTPUT,
   output logic O_TIMER0_OUTPUT_COMPLEMENT
);

   // ==========================================================
   // functions
   // looks up an address in a per-timer table: {hit, index}
   function automatic logic [3:0] lookup(input logic [31:0] addr,
      input logic [4:0][31:0] table_in);
      lookup = 4'h0;
      for (int i = 0; i < pwm_timer_pkg::NUM_TIMERS; i++) begin
         if (table_in[i] == addr) begin
            lookup = {1'b1, 3'(i)};
         end
      end
   endfunction

   // pulls one timer's control bits out of the control register
   function automatic pwm_timer_pkg::chan_ctrl_t ctl_of(
      input logic [31:0] ctl, input int idx);
      logic [4:0] b;
      b = pwm_timer_pkg::CTL_BASE[idx];
      ctl_of.start = ctl[b + pwm_timer_pkg::OFS_START];
      ctl_of.manual_update = ctl[b + pwm_timer_pkg::OFS_MANUAL];
      if (idx == int'(pwm_timer_pkg::T4)) begin
         // timer 4 has no inverter; auto-reload sits one lower
         ctl_of.invert = 1'b0;
         ctl_of.auto_reload = ctl[b + pwm_timer_pkg::OFS_T4_AR];
      end else begin
         ctl_of.invert = ctl[b + pwm_timer_pkg::OFS_INV];
         ctl_of.auto_reload = ctl[b + pwm_timer_pkg::OFS_AR];
      end
   endfunction

   // divider select to counter mask; codes 0011 and above act as 1/16
   function automatic logic [3:0] div_mask(input logic [3:0] sel);
      case (sel)
         pwm_timer_pkg::DIV_SEL_2: div_mask = pwm_timer_pkg::DIV_MASK_2;
         pwm_timer_pkg::DIV_SEL_4: div_mask = pwm_timer_pkg::DIV_MASK_4;
         pwm_timer_pkg::DIV_SEL_8: div_mask = pwm_timer_pkg::DIV_MASK_8;
         default: div_mask = pwm_timer_pkg::DIV_MASK_16;
      endcase
   endfunction

   // ==========================================================
   // declarations
   logic [31:0] cfg0_reg, cfg0_next; // prescaler_deadzone_config
   logic [31:0] cfg1_reg, cfg1_next; // divider_dma_select_config
   logic [31:0] ctl_reg, ctl_next; // timer_control
   pwm_timer_pkg::chan_buf_t buf_reg [5]; // count/compare buffers
   pwm_timer_pkg::chan_buf_t buf_next [5];
   logic [31:0] prdata_reg, prdata_next; // apb read data
   logic pready_reg, pready_next; // apb ready, one wait state
   logic pslverr_reg, pslverr_next; // unmapped address answer
   logic [31:0] rd_data; // read mux result
   logic rd_hit; // address is mapped
   logic access; // apb access phase
   logic fire; // write commits at this edge
   logic [3:0] hit_cnt, hit_cmp, hit_obs; // table lookups
   logic [7:0] pre_cnt_reg [2], pre_cnt_next [2]; // prescalers
   logic [1:0] pre_tick_reg, pre_tick_next; // prescaler outputs
   logic [3:0] div_cnt_reg [5], div_cnt_next [5]; // dividers
   logic [4:0] timer_tick; // per-timer tick
   pwm_timer_pkg::chan_ctrl_t chan_ctrl [5]; // decoded control
   logic [pwm_timer_pkg::CNT_W-1:0] chan_count [5]; // observed
   logic [4:0] chan_level; // raw output levels
   logic [4:0] chan_zero; // reach-zero events
   logic [3:0] lvl; // levels after inverter
   logic [7:0] dz_cnt_reg, dz_cnt_next; // dead-zone gap counter
   logic dz_prev_reg, dz_prev_next; // last timer 0 level
   logic gap_done; // no gap in progress
   logic [3:0] tout_reg, tout_next; // output pins
   logic tout_n_reg, tout_n_next; // complement pin
   logic [4:0] int_reg, int_next; // interrupt pulses
   logic [4:0] dma_mask; // channel picked for DMA
   logic [3:0] dma_sel; // DMA select field
   pwm_timer_pkg::dma_state_t dma_state_reg, dma_state_next;
   logic dma_n_reg, dma_n_next; // request pin, active low

   // ==========================================================
   // apb decode and read mux
   assign access = I_PSEL && I_PENABLE;
   assign fire = access && I_PWRITE && pready_reg;
   assign hit_cnt = lookup(I_PADDR, pwm_timer_pkg::ADDR_CNT_BUF);
   assign hit_cmp = lookup(I_PADDR, pwm_timer_pkg::ADDR_CMP_BUF);
   assign hit_obs = lookup(I_PADDR, pwm_timer_pkg::ADDR_OBS);

   always_comb begin
      rd_data = pwm_timer_pkg::RESET_WORD;
      rd_hit = 1'b1;
      case (I_PADDR)
         pwm_timer_pkg::ADDR_CFG0: rd_data = cfg0_reg;
         pwm_timer_pkg::ADDR_CFG1: rd_data = cfg1_reg;
         pwm_timer_pkg::ADDR_CTL: rd_data = ctl_reg;
         default: begin
            // buffers read back what was written, not the counter
            if (hit_cnt[3]) begin
               rd_data = {16'h0000, buf_reg[hit_cnt[2:0]].count};
            end else if (hit_cmp[3] && hit_cmp[2:0] != pwm_timer_pkg::T4) begin
               rd_data = {16'h0000, buf_reg[hit_cmp[2:0]].compare};
            end else if (hit_obs[3]) begin
               rd_data = {16'h0000, chan_count[hit_obs[2:0]]};
            end else begin
               rd_hit = 1'b0;
            end
         end
      endcase
   end

   // ==========================================================
   // apb answer: ready one cycle into the access phase
   always_comb begin
      pready_next = access && !pready_reg;
      prdata_next = prdata_reg;
      pslverr_next = 1'b0;
      if (access && !pready_reg) begin
         prdata_next = I_PWRITE ? pwm_timer_pkg::RESET_WORD : rd_data;
         pslverr_next = !rd_hit;
      end
   end

   // ==========================================================
   // register writes; reserved bits are dropped
   always_comb begin
      cfg0_next = cfg0_reg;
      cfg1_next = cfg1_reg;
      ctl_next = ctl_reg;
      for (int i = 0; i < pwm_timer_pkg::NUM_TIMERS; i++) begin
         buf_next[i] = buf_reg[i];
      end
      if (fire) begin
         case (I_PADDR)
            pwm_timer_pkg::ADDR_CFG0: begin
               cfg0_next = I_PWDATA & pwm_timer_pkg::MASK_CFG;
            end
            pwm_timer_pkg::ADDR_CFG1: begin
               cfg1_next = I_PWDATA & pwm_timer_pkg::MASK_CFG;
            end
            pwm_timer_pkg::ADDR_CTL: begin
               ctl_next = I_PWDATA & pwm_timer_pkg::MASK_CTL;
            end
            default: begin
               if (hit_cnt[3]) begin
                  buf_next[hit_cnt[2:0]].count = I_PWDATA[15:0];
               end
               if (hit_cmp[3] && hit_cmp[2:0] != pwm_timer_pkg::T4) begin
                  buf_next[hit_cmp[2:0]].compare = I_PWDATA[15:0];
               end
            end
         endcase
      end
   end

   // ==========================================================
   // prescalers: one tick every (value + 1) clocks
   always_comb begin
      for (int g = 0; g < 2; g++) begin
         pre_cnt_next[g] = pre_cnt_reg[g] + pwm_timer_pkg::BYTE_ONE;
         pre_tick_next[g] = 1'b0;
         if (pre_cnt_reg[g] >= (g == 0
               ? cfg0_reg[pwm_timer_pkg::PRE0_LSB +: pwm_timer_pkg::PRE_W]
               : cfg0_reg[pwm_timer_pkg::PRE1_LSB +: pwm_timer_pkg::PRE_W])) begin
            // >= also recovers when the value shrinks mid-count
            pre_cnt_next[g] = pwm_timer_pkg::BYTE_ZERO;
            pre_tick_next[g] = 1'b1;
         end
      end
   end

   // ==========================================================
   // dividers: free-running, so the first tick after start may
   // come early by up to one divider period
   always_comb begin
      for (int i = 0; i < pwm_timer_pkg::NUM_TIMERS; i++) begin
         div_cnt_next[i] = div_cnt_reg[i];
         if (pre_tick_reg[pwm_timer_pkg::TIMER_GROUP[i]]) begin
            div_cnt_next[i] = div_cnt_reg[i] + pwm_timer_pkg::NIB_ONE;
         end
         timer_tick[i] = pre_tick_reg[pwm_timer_pkg::TIMER_GROUP[i]]
            && ((div_cnt_reg[i] & div_mask(cfg1_reg[4*i +: 4]))
               == div_mask(cfg1_reg[4*i +: 4]));
      end
   end

   // ==========================================================
   // channels
   genvar gi;
   generate
      for (gi = 0; gi < pwm_timer_pkg::NUM_TIMERS; gi++) begin : g_ch
         assign chan_ctrl[gi] = ctl_of(ctl_reg, gi);
         timer_channel #(
            .HAS_COMPARE(gi != int'(pwm_timer_pkg::T4))
         ) u_channel (
            .i_clk(I_CLK),
            .i_reset(I_RESET),
            .i_tick(timer_tick[gi]),
            .i_ctrl(chan_ctrl[gi]),
            .i_buf(buf_reg[gi]),
            .o_count(chan_count[gi]),
            .o_level(chan_level[gi]),
            .o_zero(chan_zero[gi])
         );
      end
      for (gi = 0; gi < pwm_timer_pkg::NUM_OUT; gi++) begin : g_inv
         // inverter acts at once, even on a stopped timer
         assign lvl[gi] = chan_level[gi] ^ chan_ctrl[gi].invert;
      end
   endgenerate

   // ==========================================================
   // dead zone: on each edge of timer 0 both pins stay low for
   // the programmed number of timer 0 ticks
   always_comb begin
      dz_prev_next = lvl[0];
      dz_cnt_next = dz_cnt_reg;
      if (lvl[0] != dz_prev_reg) begin
         dz_cnt_next = cfg0_reg[pwm_timer_pkg::DZ_LSB +: 8];
      end else if (timer_tick[0] && dz_cnt_reg != pwm_timer_pkg::BYTE_ZERO) begin
         dz_cnt_next = dz_cnt_reg - pwm_timer_pkg::BYTE_ONE;
      end
      gap_done = (dz_cnt_next == pwm_timer_pkg::BYTE_ZERO);
      tout_next = lvl;
      tout_n_next = !lvl[0];
      if (ctl_reg[pwm_timer_pkg::DZ_EN_BIT]) begin
         // complement takes over the timer 1 pin while enabled
         tout_next[0] = lvl[0] && gap_done;
         tout_n_next = !lvl[0] && gap_done;
         tout_next[1] = tout_n_next;
      end
   end

   // ==========================================================
   // interrupt and DMA routing
   assign dma_sel = cfg1_reg[pwm_timer_pkg::DMA_LSB +: pwm_timer_pkg::SEL_W];
   always_comb begin
      for (int i = 0; i < pwm_timer_pkg::NUM_TIMERS; i++) begin
         // 0000 and codes above timer 4 pick no channel
         dma_mask[i] = (dma_sel == 4'(i + 1));
      end
      int_next = chan_zero & ~dma_mask;
   end

   // request stays low until acknowledged; events arriving while
   // one is pending merge into it
   always_comb begin
      dma_state_next = dma_state_reg;
      case (dma_state_reg)
         pwm_timer_pkg::DMA_IDLE: begin
            if (|(chan_zero & dma_mask)) begin
               dma_state_next = pwm_timer_pkg::DMA_PEND;
            end
         end
         pwm_timer_pkg::DMA_PEND: begin
            if (I_DMA_ACK) begin
               dma_state_next = pwm_timer_pkg::DMA_IDLE;
            end
         end
         default: dma_state_next = pwm_timer_pkg::DMA_IDLE;
      endcase
      dma_n_next = (dma_state_next != pwm_timer_pkg::DMA_PEND);
   end

   // ==========================================================
   // all state registers
   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         cfg0_reg <= pwm_timer_pkg::RESET_WORD;
         cfg1_reg <= pwm_timer_pkg::RESET_WORD;
         ctl_reg <= pwm_timer_pkg::RESET_WORD;
         for (int i = 0; i < pwm_timer_pkg::NUM_TIMERS; i++) begin
            buf_reg[i] <= '0;
            div_cnt_reg[i] <= '0;
         end
         pre_cnt_reg[0] <= pwm_timer_pkg::BYTE_ZERO;
         pre_cnt_reg[1] <= pwm_timer_pkg::BYTE_ZERO;
         pre_tick_reg <= '0;
         prdata_reg <= pwm_timer_pkg::RESET_WORD;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         dz_cnt_reg <= pwm_timer_pkg::BYTE_ZERO;
         dz_prev_reg <= 1'b0;
         tout_reg <= '0;
         tout_n_reg <= 1'b1;
         int_reg <= '0;
         dma_state_reg <= pwm_timer_pkg::DMA_IDLE;
         dma_n_reg <= 1'b1;
      end else begin
         cfg0_reg <= cfg0_next;
         cfg1_reg <= cfg1_next;
         ctl_reg <= ctl_next;
         for (int i = 0; i < pwm_timer_pkg::NUM_TIMERS; i++) begin
            buf_reg[i] <= buf_next[i];
            div_cnt_reg[i] <= div_cnt_next[i];
         end
         pre_cnt_reg[0] <= pre_cnt_next[0];
         pre_cnt_reg[1] <= pre_cnt_next[1];
         pre_tick_reg <= pre_tick_next;
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
         dz_cnt_reg <= dz_cnt_next;
         dz_prev_reg <= dz_prev_next;
         tout_reg <= tout_next;
         tout_n_reg <= tout_n_next;
         int_reg <= int_next;
         dma_state_reg <= dma_state_next;
         dma_n_reg <= dma_n_next;
      end
   end

   // ==========================================================
   // outputs, each straight from a flip-flop
   assign O_PRDATA = prdata_reg;
   assign O_PREADY = pready_reg;
   assign O_PSLVERR = pslverr_reg;
   assign O_DMA_REQUEST_N = dma_n_reg;
   assign O_INT_REQUEST = int_reg;
   assign O_TIMER_OUTPUT = tout_reg;
   assign O_TIMER0_OUTPUT_COMPLEMENT = tout_n_reg;

endmodule

// [pwm_timer_control_chk.sv]
`timescale 1ns/1ps
// ==========================================================
// bus and request checks, seen from the top ports only
module pwm_timer_control_chk (
   input wire logic I_CLK,
   input wire logic I_RESET,
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic O_PREADY,
   input wire logic O_PSLVERR,
   input wire logic I_DMA_ACK,
   input wire logic O_DMA_REQUEST_N,
   input wire logic [4:0] O_INT_REQUEST
);
   default clocking @(posedge I_CLK);
   endclocking
   default disable iff (I_RESET);
   // ==========================================================
   // bus transfer steps
   // setup cycle followed by the first access cycle
   sequence fresh_access_s;
      I_PSEL && !I_PENABLE ##1 I_PSEL && I_PENABLE;
   endsequence
   // the slave always inserts exactly one wait state
   ready_latency_a: assert property (fresh_access_s |=> O_PREADY)
      else $error("ready not one cycle after access");
   ready_pulse_a: assert property (O_PREADY |=> !O_PREADY)
      else $error("ready held too long");
   ready_in_access_a: assert property (O_PREADY |-> I_PSEL && I_PENABLE)
      else $error("ready outside an access");
   err_with_ready_a: assert property (O_PSLVERR |-> O_PREADY)
      else $error("error without ready");
   // ==========================================================
   // request handshake towards the transfer engine
   dma_hold_a: assert property (!O_DMA_REQUEST_N && !I_DMA_ACK |=> !O_DMA_REQUEST_N)
      else $error("request dropped before acknowledge");
   dma_release_a: assert property (!O_DMA_REQUEST_N && I_DMA_ACK |=> O_DMA_REQUEST_N)
      else $error("request kept after acknowledge");
   dma_start_a: assert property ($fell(O_DMA_REQUEST_N) |-> !$past(I_DMA_ACK))
      else $error("request raised by an acknowledge");
   // events are single-cycle pulses
   int_pulse_a: assert property (|O_INT_REQUEST |=> (O_INT_REQUEST & $past(O_INT_REQUEST)) == 5'h00)
      else $error("interrupt pulse too long");
endmodule
bind pwm_timer_control pwm_timer_control_chk i_chk (.I_CLK, .I_RESET,
   .I_PSEL, .I_PENABLE, .O_PREADY, .O_PSLVERR, .I_DMA_ACK,
   .O_DMA_REQUEST_N, .O_INT_REQUEST);

// [pwm_timer_control_tb_top.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; \
   $display("[FAIL] %0t got %h want %h", $time, (a), (b)); end end
module pwm_timer_control_tb_top;
   // ==========================================================
   // stimulus and observed signals
   localparam logic [31:0] CFG0 = pwm_timer_pkg::ADDR_CFG0;
   localparam logic [31:0] CFG1 = pwm_timer_pkg::ADDR_CFG1;
   localparam logic [31:0] CTL = pwm_timer_pkg::ADDR_CTL;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0000_0000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, rv;
   logic pready, pslverr, ack, req_n, tout_n, re;
   logic [4:0] irq;
   logic [3:0] tout;
   logic [3:0] dly = 4'h1; // partner answer delay
   int fails = 0;
   int cmp_count = 0;
   int cyc = 0;
   initial begin
      forever #5 clk = ~clk;
   end
   pwm_timer_control i_pwm_timer_control (.I_CLK(clk), .I_RESET(rst),
      .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
      .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
      .O_PREADY(pready), .O_PSLVERR(pslverr), .I_DMA_ACK(ack),
      .O_DMA_REQUEST_N(req_n), .O_INT_REQUEST(irq),
      .O_TIMER_OUTPUT(tout), .O_TIMER0_OUTPUT_COMPLEMENT(tout_n));
   dma_partner i_dma_partner (.i_clk(clk), .i_reset(rst), .i_delay(dly),
      .i_dma_request_n(req_n), .o_dma_ack(ack));
   // ==========================================================
   // bus master: one idle edge first, so no signal is set twice;
   // it waits for ready as long as it takes, the hang guard ends it
   task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rv = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // cycles between two timer 0 events, 300 if none
   task int_gap(output int n);
      for (n = 0; n < 300 && irq[0] !== 1'b1; n++) @(posedge clk);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (n < 300 && irq[0] !== 1'b1);
   endtask
   // ==========================================================
   // scenarios
   task t_regs;
      logic [31:0] m [5];
      m = '{32'h00FF_FFFF, 32'h00FF_FFFF, 32'h007F_FF1F, 32'h0000_FFFF,
         32'h0000_FFFF};
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, CFG0 + 32'(i * 4), 32'h0000_0000);
         `CHK({re, rv}, 33'h0_0000_0000)
         apb(1'b1, CFG0 + 32'(i * 4), 32'hFFFF_FFFF);
         apb(1'b0, CFG0 + 32'(i * 4), 32'h0000_0000);
         `CHK(rv, m[i])
         apb(1'b1, CFG0 + 32'(i * 4), 32'h0000_0000);
      end
      apb(1'b0, 32'h5100_0044, 32'h0000_0000); // unmapped
      `CHK(re, 1'b1)
      // timer 4 manual update loads its counter, seen at observation
      apb(1'b1, 32'h5100_003C, 32'h0000_0005);
      apb(1'b1, CTL, 32'h0020_0000);
      apb(1'b0, 32'h5100_0040, 32'h0000_0000);
      `CHK(rv, 32'h0000_0005)
      apb(1'b1, CTL, 32'h0000_0000);
   endtask
   // dead zone: both pins low for about two timer 0 ticks of 8 clocks
   task t_dead;
      apb(1'b1, CFG0, 32'h0002_0001);
      apb(1'b1, CTL, 32'h0000_0015);
      repeat (2) @(posedge clk);
      `CHK({tout, tout_n}, 5'b11101)
      apb(1'b1, CTL, 32'h0000_0011);
      repeat (8) @(posedge clk);
      `CHK({tout, tout_n}, 5'b11000)
      repeat (24) @(posedge clk);
      `CHK({tout, tout_n}, 5'b11010)
   endtask
   task t_timer0;
      int n;
      apb(1'b1, CFG0, 32'h0000_0001);
      apb(1'b1, CFG1, 32'h0000_0001);
      apb(1'b1, CTL + 32'h0000_0004, 32'h0000_0003);
      apb(1'b1, CTL + 32'h0000_0008, 32'h0000_0001);
      apb(1'b1, CTL, 32'h0000_000A);
      apb(1'b1, CTL, 32'h0000_0009);
      int_gap(n);
      `CHK(n, 32)
      apb(1'b1, CTL, 32'h0000_0001);
      int_gap(n);
      `CHK(n, 300)
      `CHK({tout[0], tout_n}, 2'b10)
      apb(1'b1, CTL, 32'h0000_0005);
      repeat (3) @(posedge clk);
      `CHK(tout[0], 1'b0)
   endtask
   task t_dma;
      int ints, lows;
      for (int c = 0; c < 7; c++) begin
         dly <= 4'(c);
         apb(1'b1, CFG1, {8'h00, 4'(c), 20'h0_0001});
         apb(1'b1, CTL, 32'h0000_000A);
         apb(1'b1, CTL, 32'h0000_0009);
         ints = 0;
         lows = 0;
         repeat (80) begin
            @(posedge clk);
            ints += int'(irq[0] === 1'b1);
            lows += int'(req_n === 1'b0);
         end
         `CHK(ints == 0, c == 1)
         `CHK(lows > 0, c == 1)
         apb(1'b1, CTL, 32'h0000_0000);
      end
   endtask
   // ==========================================================
   // verdict, main sequence and hang guard
   task print_verdict;
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      t_regs;
      t_timer0;
      t_dead;
      t_dma;
      print_verdict;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 6000) begin
         fails++;
         print_verdict;
      end
   end
endmodule

// [pwm_timer_pkg.sv]
package pwm_timer_pkg;

   // ==========================================================
   // sizes
   localparam int NUM_TIMERS = 5;
   localparam int NUM_OUT = 4;            // timers with an output pin
   localparam int CNT_W = 16;
   localparam int PRE_W = 8;
   localparam int SEL_W = 4;
   localparam logic [2:0] T4 = 3'h4;      // timer without compare
   localparam logic [4:0] TIMER_GROUP = 5'b1_1100; // prescaler per timer

   // ==========================================================
   // register byte addresses
   localparam logic [31:0] ADDR_CFG0 = 32'h5100_0000;
   localparam logic [31:0] ADDR_CFG1 = 32'h5100_0004;
   localparam logic [31:0] ADDR_CTL = 32'h5100_0008;
   localparam logic [4:0][31:0] ADDR_CNT_BUF = {32'h5100_003C,
      32'h5100_0030, 32'h5100_0024, 32'h5100_0018, 32'h5100_000C};
   // timer 4 has no compare buffer; a hit on its slot is discarded
   localparam logic [4:0][31:0] ADDR_CMP_BUF = {32'h0000_0000,
      32'h5100_0034, 32'h5100_0028, 32'h5100_001C, 32'h5100_0010};
   localparam logic [4:0][31:0] ADDR_OBS = {32'h5100_0040,
      32'h5100_0038, 32'h5100_002C, 32'h5100_0020, 32'h5100_0014};

   // ==========================================================
   // reset values and writable-bit masks
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
   localparam logic [15:0] RESET_HALF = 16'h0000;
   localparam logic [31:0] MASK_CFG = 32'h00FF_FFFF;
   localparam logic [31:0] MASK_CTL = 32'h007F_FF1F; // [7:5] reserved

   // ==========================================================
   // field positions
   localparam int PRE0_LSB = 0;
   localparam int PRE1_LSB = 8;
   localparam int DZ_LSB = 16;
   localparam int DMA_LSB = 20;
   localparam int DZ_EN_BIT = 4;
   localparam logic [4:0][4:0] CTL_BASE = {5'h14, 5'h10, 5'h0C,
      5'h08, 5'h00};
   localparam logic [4:0] OFS_START = 5'h00;
   localparam logic [4:0] OFS_MANUAL = 5'h01;
   localparam logic [4:0] OFS_INV = 5'h02;
   localparam logic [4:0] OFS_AR = 5'h03;
   localparam logic [4:0] OFS_T4_AR = 5'h02;

   // ==========================================================
   // divider select codes and counter masks
   localparam logic [3:0] DIV_SEL_2 = 4'h0;
   localparam logic [3:0] DIV_SEL_4 = 4'h1;
   localparam logic [3:0] DIV_SEL_8 = 4'h2;
   localparam logic [3:0] DIV_MASK_2 = 4'h1;
   localparam logic [3:0] DIV_MASK_4 = 4'h3;
   localparam logic [3:0] DIV_MASK_8 = 4'h7;
   localparam logic [3:0] DIV_MASK_16 = 4'hF;
   localparam logic [3:0] DMA_SEL_NONE = 4'h0;

   // ==========================================================
   // small constants
   localparam logic [15:0] CNT_ONE = 16'h0001;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] BYTE_ONE = 8'h01;
   localparam logic [3:0] NIB_ONE = 4'h1;

   // ==========================================================
   // carriers
   typedef struct packed {
      logic start;
      logic manual_update;
      logic auto_reload;
      logic invert;
   } chan_ctrl_t;

   typedef struct packed {
      logic [CNT_W-1:0] count;
      logic [CNT_W-1:0] compare;
   } chan_buf_t;

   typedef enum logic [1:0] {
      DMA_IDLE = 2'b01,
      DMA_PEND = 2'b10
   } dma_state_t;

endpackage

// [timer_channel.sv]
`timescale 1ns/1ps
// ==========================================================
// one down-counting timer with its working counter and compare
module timer_channel #(
   parameter bit HAS_COMPARE = 1'b1
) (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_tick,
   input wire pwm_timer_pkg::chan_ctrl_t i_ctrl,
   input wire pwm_timer_pkg::chan_buf_t i_buf,
   output logic [pwm_timer_pkg::CNT_W-1:0] o_count,
   output logic o_level,
   output logic o_zero
);

   logic [pwm_timer_pkg::CNT_W-1:0] cnt_reg, cnt_next; // working counter
   logic [pwm_timer_pkg::CNT_W-1:0] cmp_reg, cmp_next; // working compare
   logic level_reg, level_next; // raw output before inverter
   logic zero_reg, zero_next; // one-cycle reach-zero event

   // ==========================================================
   // next state of counter, compare and output level
   always_comb begin
      cnt_next = cnt_reg;
      cmp_next = cmp_reg;
      zero_next = 1'b0;
      // manual update is level-sensitive: it loads on every cycle
      // while set, so software must drop it on the next write
      if (i_ctrl.manual_update) begin
         cnt_next = i_buf.count;
         if (HAS_COMPARE) begin
            cmp_next = i_buf.compare;
         end
         // timer 4 keeps its compare untouched
      end else if (i_ctrl.start && i_tick) begin
         if (cnt_reg != pwm_timer_pkg::RESET_HALF) begin
            // count down; the event marks arrival at zero
            cnt_next = cnt_reg - pwm_timer_pkg::CNT_ONE;
            zero_next = (cnt_reg == pwm_timer_pkg::CNT_ONE);
         end else if (i_ctrl.auto_reload) begin
            // reload lands one tick after reaching zero
            cnt_next = i_buf.count;
            if (HAS_COMPARE) begin
               cmp_next = i_buf.compare;
            end
         end
         // one-shot: stays at zero, timer halted
      end
      // high once the count has come down to the compare value
      level_next = HAS_COMPARE && (cnt_next <= cmp_next);
   end

   // ==========================================================
   // state registers
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         cnt_reg <= pwm_timer_pkg::RESET_HALF;
         cmp_reg <= pwm_timer_pkg::RESET_HALF;
         level_reg <= 1'b0;
         zero_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         cmp_reg <= cmp_next;
         level_reg <= level_next;
         zero_reg <= zero_next;
      end
   end

   assign o_count = cnt_reg;
   assign o_level = level_reg;
   assign o_zero = zero_reg;

endmodule
